// File: bop_pkg.sv
// Shared constants, types and helpers of the bridge protection block
package bop_pkg;
	localparam int NB = 4;                  // Half bridges A to D
	localparam int NSYNC = 18;              // Synchronised pin inputs
	localparam int CLK_NS = 20;             // Clock period in ns
	localparam int SHORT_NS = 1000;         // Trip held while limiting that counts as a short
	localparam int SHORT_CYC = (SHORT_NS + CLK_NS - 1) / CLK_NS;
	// Positions in the synchronised input vector
	localparam int SY_OCH = 0;
	localparam int SY_OCL = 4;
	localparam int SY_PWM = 8;
	localparam int SY_WARN = 12;
	localparam int SY_HOT = 13;
	localparam int SY_CLR = 14;
	localparam int SY_FPIN = 16;
	localparam int SY_WPIN = 17;
	localparam logic [NSYNC-1:0] SYNC_RST = 18'h00000;
	// Register byte offsets
	localparam logic [7:0] OFS_STATE = 8'h00;
	localparam logic [7:0] OFS_ISTAT = 8'h04;
	localparam logic [7:0] OFS_IMASK = 8'h08;
	localparam logic [9:0] IMASK_RST = 10'h000;
	localparam logic [9:0] ISTAT_RST = 10'h000;
	// Bridge state, Gray coded along run, limit, shutdown
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_LIM_LS = 2'b01,
		ST_LIM_HS = 2'b11,
		ST_SHUT   = 2'b10
	} bop_st_t;
	// Interrupt events; layout of status and mask registers
	typedef struct packed {
		logic       tsd;
		logic       overtemp_warning_n;
		logic [3:0] lim;
		logic [3:0] shut;
	} bop_evt_t;
	// Gate commands of one half bridge
	typedef struct packed {
		logic hs;
		logic ls;
		logic hiz;
		logic pd;
	} bop_gate_t;
	// True while a bridge is in either limiting state
	function automatic logic bop_limiting(bop_st_t s);
		return (s == ST_LIM_LS) || (s == ST_LIM_HS);
	endfunction : bop_limiting
endpackage : bop_pkg

// File: bop_sync.sv
// Three-stage input synchroniser; output changes once stages two and three agree
module bop_sync #(
	parameter int              W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_q, s2_q, s3_q;
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);

	// Shift chain and agreement filter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			q_o  <= RST;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_o  <= (s3_q & agree) | (q_o & ~agree);
		end
	end
endmodule : bop_sync

// File: bop_bridge.sv
// Overcurrent limiting and latching shutdown of one half bridge
module bop_bridge
	import bop_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  latch_mode_i,
	input  wire logic  pwm_i,
	input  wire logic  pwm_rise_i,
	input  wire logic  oc_hs_i,
	input  wire logic  oc_ls_i,
	input  wire logic  clr_rise_i,
	input  wire logic  hold_i,
	input  wire logic  tsd_i,
	output bop_gate_t  gate_o,
	output bop_st_t    state_o,
	output logic       lim_evt_o,
	output logic       shut_evt_o
);
	bop_st_t    st_q, st_d;
	logic [7:0] cnt_q;
	wire        oc = oc_hs_i | oc_ls_i;
	wire        lim = bop_limiting(st_q);
	wire        short_hit = lim && oc && (cnt_q == 8'(SHORT_CYC - 1));

	// Next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_RUN: begin
				if (oc && latch_mode_i)
					st_d = ST_SHUT; // R7
				else if (oc_hs_i)
					st_d = ST_LIM_HS; // R6
				else if (oc_ls_i)
					st_d = ST_LIM_LS; // R5
			end
			ST_LIM_LS, ST_LIM_HS: begin
				if (short_hit)
					st_d = ST_SHUT; // R4
				else if (pwm_rise_i)
					st_d = ST_RUN; // R15
			end
			ST_SHUT: begin
				if (clr_rise_i)
					st_d = ST_RUN; // R13
			end
		endcase
	end

	// State and persistence counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q  <= ST_RUN;
			cnt_q <= 8'h00;
		end else begin
			st_q  <= st_d;
			cnt_q <= (lim && oc) ? cnt_q + 8'h01 : 8'h00; // R4
		end
	end

	// Gate commands; limiting overrides the PWM until the next cycle
	assign gate_o.hiz = (st_q == ST_SHUT) || hold_i || tsd_i; // R4 R11 R14
	assign gate_o.pd  = hold_i; // R14
	assign gate_o.hs  = !gate_o.hiz && st_q == ST_RUN && pwm_i; // R5 R6
	assign gate_o.ls  = !gate_o.hiz && ((st_q == ST_RUN && !pwm_i) || st_q == ST_LIM_HS); // R5 R6
	assign state_o    = st_q;
	assign lim_evt_o  = !lim && bop_limiting(st_d);
	assign shut_evt_o = st_q != ST_SHUT && st_d == ST_SHUT;

	// Assertion helper: cycles in a row spent limiting with the trip present
	logic [7:0] trip_run_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trip_run_q <= 8'h00;
		end else begin
			trip_run_q <= (lim && oc) ? trip_run_q + 8'h01 : 8'h00;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	lim_ls_off_a: assert property (st_q == ST_LIM_LS |-> !gate_o.hs && !gate_o.ls) // R5
		else $error("low-side limit left a FET on");
	lim_hs_ls_a: assert property (st_q == ST_LIM_HS |-> !gate_o.hs && gate_o.ls == !gate_o.hiz) // R6
		else $error("high-side limit did not swap to low side");
	latch_shut_a: assert property (st_q == ST_RUN && latch_mode_i && oc |=> st_q == ST_SHUT) // R7
		else $error("latched mode did not shut down");
	limit_recover_a: assert property (lim && pwm_rise_i && !short_hit |=> st_q == ST_RUN) // R15
		else $error("limit not released on PWM cycle start");
	limit_hold_a: assert property (lim && !pwm_rise_i && !short_hit |=> lim) // R15
		else $error("limit released before next PWM cycle");
	short_latch_a: assert property (lim && oc && trip_run_q == 8'(SHORT_CYC - 1) // R4
		|=> st_q == ST_SHUT)
		else $error("persistent trip did not latch a shutdown");
	short_early_a: assert property (lim && trip_run_q < 8'(SHORT_CYC - 1) |=> st_q != ST_SHUT) // R4
		else $error("limiting bridge latched off before the short threshold");
	shut_clear_a: assert property (st_q == ST_SHUT && clr_rise_i |=> st_q == ST_RUN) // R13
		else $error("clear edge did not release shutdown");
	shut_stay_a: assert property (st_q == ST_SHUT && !clr_rise_i |=> st_q == ST_SHUT) // R7
		else $error("shutdown released without clear edge");
	cov_limit_c: cover property (st_q == ST_LIM_HS ##[1:200] st_q == ST_RUN);
	cov_short_c: cover property (lim ##1 st_q == ST_SHUT);
endmodule : bop_bridge

// File: bop_top.sv
// Overcurrent and thermal protection of a four half-bridge stage, AHB-Lite registers
// Contract
// R1: Each half bridge watches its own high and low FET trip independently.
// R2: Static mode pin picks cycle limiting or latched overcurrent shutdown.
// R3: Cycle limiting steers the bridge so current stops rising, no shutdown.
// R4: A trip that limiting cannot contain latches that bridge into high impedance.
// R5: Low-side trip turns low FET off, high FET held off until next cycle.
// R6: High-side trip turns high FET off, low FET on until next cycle.
// R7: Latched mode: any trip shuts the bridge at once and holds it.
// R8: Controller pulses the pair clear after an overcurrent shutdown is gone.
// R9: Highest trip current setting is only for latched overcurrent mode.
// R10: Warning output low while junction is above the warning level.
// R11: Above shutdown level all bridges go high impedance and fault goes low.
// R12: Thermal shutdown latches; both pair clears must be driven low to clear.
// R13: Clear rising edge releases that pair; thermal needs edges on both.
// R14: Pair clear held low forces its bridges high impedance with weak pulldown.
// R15: A limited bridge stays off until its PWM input starts a new cycle.
// R16: Fault and warning are active-low open drain; fault low on any shutdown.
// R17: Pin inputs are synchronised and filtered so one event acts once. LATCH_MODE_I is used without the filter.
//
// Our own choices: the register addresses and the AHB-Lite register port.
module bop_top
	import bop_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_B_I,
	// AHB-Lite slave
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// Controller side
	input  wire logic        LATCH_MODE_I,
	input  wire logic [3:0]  PWM_I,
	input  wire logic        FIRST_PAIR_CLEAR_N_I,
	input  wire logic        SECOND_PAIR_CLEAR_N_I,
	// Detectors and temperature comparators
	input  wire logic [3:0]  OC_HS_I,
	input  wire logic [3:0]  OC_LS_I,
	input  wire logic        TEMP_WARN_I,
	input  wire logic        TEMP_HOT_I,
	// Power stage gate commands
	output logic      [3:0]  HS_ON_O,
	output logic      [3:0]  LS_ON_O,
	output logic      [3:0]  HIZ_O,
	output logic      [3:0]  PULLDOWN_O,
	// Open-drain status pins
	input  wire logic        FAULT_N_I,
	output logic             FAULT_N_O,
	output logic             FAULT_N_OE_O,
	input  wire logic        OVERTEMP_WARNING_N_I,
	output logic             OVERTEMP_WARNING_N_O,
	output logic             OVERTEMP_WARNING_N_OE_O,
	// Interrupt
	output logic             IRQ_O
);
	logic             rs1_q, rst_n;
	logic [NSYNC-1:0] sy;
	logic [3:0]       pwm_prev_q;
	logic [1:0]       clr_prev_q, tclr_q;
	logic             tsd_q, hot_prev_q, warn_prev_q;
	bop_gate_t        gate [NB];
	bop_st_t          st [NB];
	logic [3:0]       lim_evt, shut_evt, shut_lvl, lim_lvl;
	bop_evt_t         ist_q, imask_q, evt;
	logic             ap_wr_q;
	logic [7:0]       ap_addr_q;

	// Reset release through two flops
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	// Every pin input except LATCH_MODE_I and the bus passes the three-stage filter
	bop_sync #(.W(NSYNC), .RST(SYNC_RST)) u_sync ( // R17
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.d_i     ({OVERTEMP_WARNING_N_I, FAULT_N_I, SECOND_PAIR_CLEAR_N_I,
			FIRST_PAIR_CLEAR_N_I, TEMP_HOT_I, TEMP_WARN_I, PWM_I, OC_LS_I, OC_HS_I}),
		.q_o     (sy)
	);

	// Filtered pin fields and edges
	wire [3:0] pwm      = sy[SY_PWM +: 4];
	wire [3:0] pwm_rise = pwm & ~pwm_prev_q; // R15
	wire [1:0] clr      = sy[SY_CLR +: 2];
	wire [1:0] clr_rise = clr & ~clr_prev_q; // R13
	wire       warn     = sy[SY_WARN];
	wire       hot      = sy[SY_HOT];
	wire       latch    = LATCH_MODE_I; // R2

	// Edge history
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pwm_prev_q  <= 4'h0;
			clr_prev_q  <= 2'h0;
			hot_prev_q  <= 1'b0;
			warn_prev_q <= 1'b0;
		end else begin
			pwm_prev_q  <= pwm;
			clr_prev_q  <= clr;
			hot_prev_q  <= hot;
			warn_prev_q <= warn;
		end
	end

	// Thermal latch: set wins; cleared once both pairs saw a rising clear
	wire tclr_done = &(tclr_q | clr_rise);
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			tsd_q  <= 1'b0;
			tclr_q <= 2'h0;
		end else begin
			tsd_q  <= hot || (tsd_q && !tclr_done); // R11 R12 R13
			tclr_q <= (tsd_q && !tclr_done) ? (tclr_q | clr_rise) : 2'h0; // R12
		end
	end

	// One independent protection cell per half bridge
	for (genvar b = 0; b < NB; b++) begin : g_br // R1
		bop_bridge u_br (
			.clk_i        (CLK_I),
			.rst_n_i      (rst_n),
			.latch_mode_i (latch),
			.pwm_i        (pwm[b]),
			.pwm_rise_i   (pwm_rise[b]),
			.oc_hs_i      (sy[SY_OCH + b]),
			.oc_ls_i      (sy[SY_OCL + b]),
			.clr_rise_i   (clr_rise[b / 2]),
			.hold_i       (!clr[b / 2]),
			.tsd_i        (tsd_q),
			.gate_o       (gate[b]),
			.state_o      (st[b]),
			.lim_evt_o    (lim_evt[b]),
			.shut_evt_o   (shut_evt[b])
		);
		assign shut_lvl[b] = st[b] == ST_SHUT;
		assign lim_lvl[b]  = bop_limiting(st[b]); // R3

		// Registered gate commands
		always_ff @(posedge CLK_I or negedge rst_n) begin
			if (!rst_n) begin
				HS_ON_O[b]    <= 1'b0;
				LS_ON_O[b]    <= 1'b0;
				HIZ_O[b]      <= 1'b1;
				PULLDOWN_O[b] <= 1'b1;
			end else begin
				HS_ON_O[b]    <= gate[b].hs;
				LS_ON_O[b]    <= gate[b].ls;
				HIZ_O[b]      <= gate[b].hiz;
				PULLDOWN_O[b] <= gate[b].pd;
			end
		end
	end

	// Open-drain status pins; enable pulls the pin low
	wire fault = (|shut_lvl) || tsd_q; // R16
	assign FAULT_N_O            = 1'b0;
	assign OVERTEMP_WARNING_N_O = 1'b0;
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			FAULT_N_OE_O            <= 1'b0;
			OVERTEMP_WARNING_N_OE_O <= 1'b0;
		end else begin
			FAULT_N_OE_O            <= fault; // R16
			OVERTEMP_WARNING_N_OE_O <= warn; // R10
		end
	end

	// Events for the interrupt status
	assign evt.shut = shut_evt;
	assign evt.lim  = lim_evt;
	assign evt.overtemp_warning_n  = warn && !warn_prev_q;
	assign evt.tsd  = hot && !hot_prev_q;

	// AHB-Lite address phase decode; zero wait states, always OKAY
	wire ap_go = HSEL_I && HTRANS_I[1] && HREADY_I;
	wire wr_st = ap_wr_q && ap_addr_q == OFS_ISTAT;
	wire wr_mk = ap_wr_q && ap_addr_q == OFS_IMASK;
	wire [31:0] state_word = {17'h00000, sy[SY_WPIN], sy[SY_FPIN], clr, latch,
		tsd_q, warn, lim_lvl, shut_lvl};

	// Register hit: offset matches and the upper address bits are clear
	function automatic logic bop_reg_hit(input logic [31:0] a, input logic [7:0] ofs);
		return a[31:8] == 24'h000000 && a[7:0] == ofs;
	endfunction : bop_reg_hit
	wire [31:0] rd_mux =
		bop_reg_hit(HADDR_I, OFS_STATE) ? state_word :
		bop_reg_hit(HADDR_I, OFS_ISTAT) ? {22'h000000, ist_q} :
		bop_reg_hit(HADDR_I, OFS_IMASK) ? {22'h000000, imask_q} :
		32'h00000000;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = 1'b0;

	// Bus phase registers and read data
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h00;
			HRDATA_O  <= 32'h00000000;
		end else begin
			ap_wr_q   <= ap_go && HWRITE_I && HADDR_I[31:8] == 24'h000000;
			ap_addr_q <= HADDR_I[7:0];
			if (ap_go && !HWRITE_I)
				HRDATA_O <= rd_mux;
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ist_q   <= ISTAT_RST;
			imask_q <= IMASK_RST;
		end else begin
			ist_q <= (ist_q & ~(wr_st ? HWDATA_I[9:0] : 10'h000)) | evt;
			if (wr_mk)
				imask_q <= HWDATA_I[9:0];
		end
	end
	assign IRQ_O = |(ist_q & imask_q);

	default clocking @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	tsd_hiz_a: assert property (tsd_q |=> HIZ_O == 4'hf) // R11
		else $error("thermal shutdown left a bridge driven");
	tsd_set_a: assert property (hot |=> tsd_q ##1 FAULT_N_OE_O) // R11
		else $error("hot comparator did not latch shutdown and fault");
	tsd_clear_a: assert property ($fell(tsd_q) |-> $past(tclr_done) && !$past(hot)) // R12
		else $error("thermal latch cleared without both clear edges");
	tsd_one_a: assert property (tsd_q && !hot && clr_rise == 2'b01 && !tclr_q[1] |=> tsd_q) // R13
		else $error("one pair clear released thermal shutdown");
	fault_out_a: assert property (fault |=> FAULT_N_OE_O && !FAULT_N_O) // R16
		else $error("fault pin not pulled low on shutdown");
	no_fault_a: assert property (!fault |=> !FAULT_N_OE_O) // R16
		else $error("fault pin pulled without shutdown");
	warn_out_a: assert property (warn |=> OVERTEMP_WARNING_N_OE_O) // R10
		else $error("warning pin not pulled low");
	pair_hold_a: assert property (!clr[0] |=> HIZ_O[1:0] == 2'b11 && PULLDOWN_O[1:0] == 2'b11) // R14
		else $error("held pair clear did not float pair one");
	pair_two_a: assert property (!clr[1] |=> HIZ_O[3:2] == 2'b11 && !HS_ON_O[3] && !LS_ON_O[3]) // R14
		else $error("held pair clear did not float pair two");
	irq_level_a: assert property (|(evt & imask_q) |=> IRQ_O) // R16
		else $error("unmasked event raised no interrupt");

	// Gate command safety
	no_shoot_a: assert property (!(|(HS_ON_O & LS_ON_O))) // R6
		else $error("both FETs of a bridge commanded on");
	hiz_quiet_a: assert property (!(|(HIZ_O & (HS_ON_O | LS_ON_O)))) // R4
		else $error("floated bridge still has a FET on");
	pd_only_hold_a: assert property (clr == 2'b11 |=> PULLDOWN_O == 4'h0) // R14
		else $error("pulldown on without a held pair clear");
	pwm_follow_a: assert property (st[0] == ST_RUN && clr[0] && !tsd_q // R15
		|=> HS_ON_O[0] == $past(pwm[0]) && LS_ON_O[0] == !$past(pwm[0]))
		else $error("running bridge did not follow its PWM input");
	lim_event_a: assert property (|lim_evt |=> |lim_lvl) // R3
		else $error("limit event without a limiting bridge");
	shut_event_a: assert property (|shut_evt |=> |shut_lvl) // R4
		else $error("shutdown event without a latched bridge");

	// Thermal path and pin filtering
	tsd_keep_a: assert property (tsd_q && !tclr_done |=> tsd_q) // R12
		else $error("thermal latch dropped without both clear edges");
	warn_drop_a: assert property (!warn |=> !OVERTEMP_WARNING_N_OE_O) // R10
		else $error("warning pin pulled while cool");
	warn_event_a: assert property (warn && !warn_prev_q |=> ist_q.overtemp_warning_n) // R10
		else $error("warning rise not recorded in status");
	sync_hot_a: assert property ($changed(hot) |-> $past(TEMP_HOT_I, 3) == hot // R17
		&& $past(TEMP_HOT_I, 4) == hot)
		else $error("hot input changed without two agreeing samples");
	sync_warn_a: assert property ($changed(warn) |-> $past(TEMP_WARN_I, 3) == warn // R17
		&& $past(TEMP_WARN_I, 4) == warn)
		else $error("warning input changed without two agreeing samples");

	// Register bus and interrupt status
	bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready and okay");
	rd_istat_a: assert property (ap_go && !HWRITE_I && bop_reg_hit(HADDR_I, OFS_ISTAT)
		|=> HRDATA_O == {22'h000000, $past(ist_q)})
		else $error("status read returned wrong data");
	rd_mask_a: assert property (ap_go && !HWRITE_I && bop_reg_hit(HADDR_I, OFS_IMASK)
		|=> HRDATA_O == {22'h000000, $past(imask_q)})
		else $error("mask read returned wrong data");
	rd_hold_a: assert property (!(ap_go && !HWRITE_I) |=> $stable(HRDATA_O))
		else $error("read data changed without a read");
	mask_write_a: assert property (wr_mk |=> imask_q == $past(HWDATA_I[9:0]))
		else $error("mask write not applied");
	ist_set_a: assert property (|evt |=> (ist_q & $past(evt)) == $past(evt))
		else $error("event lost from the status register");
	ist_w1c_a: assert property (wr_st && HWDATA_I[9:0] == 10'h3ff && evt == 10'h000
		|=> ist_q == 10'h000)
		else $error("write one did not clear the status");
	cov_tsd_c: cover property (tsd_q ##[1:400] !tsd_q);
	cov_both_c: cover property (lim_lvl[0] && shut_lvl[2]);
	cov_irq_c: cover property (IRQ_O ##[1:50] !IRQ_O);
endmodule : bop_top

// File: bop_ctrl_model.sv
// Controller model of the bridge protection block: mode tie, PWM levels and pair clears
module bop_ctrl_model (
	// Clock
	input  wire logic       clk_i,
	// Requests from the bench
	input  wire logic       mode_i,
	input  wire logic [3:0] pwm_i,
	input  wire logic [1:0] hold_i,
	input  wire logic [1:0] pulse_i,
	// Pins towards the device
	output logic            mode_o,
	output logic      [3:0] pwm_o,
	output logic      [1:0] clr_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt_q [2];

	// Mode pin is a static tie; PWM toggles are what restart a limited bridge
	assign mode_o = mode_i;
	assign pwm_o = pwm_i;

	// Pair clears start low, as a controller holds them during power-up
	initial begin
		cnt_q = '{4'h0, 4'h0};
		clr_n_o = 2'b00;
	end

	// A clear is a low pulse ending in a rising edge, sent once the cause has gone
	always @(posedge clk_i) begin
		for (int k = 0; k < 2; k++) begin
			cnt_q[k] <= pulse_i[k] ? 4'h8 : cnt_q[k] - {3'h0, cnt_q[k] != 4'h0};
			clr_n_o[k] <= !(hold_i[k] || pulse_i[k] || cnt_q[k] > 4'h1);
		end
	end
endmodule : bop_ctrl_model

// File: bop_top_tb_top.sv
// Testbench of the bridge protection block: controller model, bus tasks and scenarios
module bop_top_tb_top
	import bop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst_b, hsel, hwrite, mode, mode_pin, hrdy, hresp, irq;
	logic        temp_warn, temp_hot, fault_o, fault_oe, warn_o, warn_oe, fault_n, warn_n;
	logic [1:0]  htrans, hold, pulse, clr_n;
	logic [2:0]  hsize;
	logic [3:0]  pwm, pwm_pin, oc_hs, oc_ls, hs_on, ls_on, hiz, pd;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	int          fails = 0;
	int          checks_done = 0;

	// Open-drain pins with their pull-ups
	assign fault_n = fault_oe ? fault_o : 1'b1;
	assign warn_n = warn_oe ? warn_o : 1'b1;

	bop_ctrl_model u_bop_ctrl_model (.clk_i(clk), .mode_i(mode), .pwm_i(pwm), .hold_i(hold),
		.pulse_i(pulse), .mode_o(mode_pin), .pwm_o(pwm_pin), .clr_n_o(clr_n));

	bop_top u_bop_top (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
		.HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.LATCH_MODE_I(mode_pin), .PWM_I(pwm_pin), .FIRST_PAIR_CLEAR_N_I(clr_n[0]),
		.SECOND_PAIR_CLEAR_N_I(clr_n[1]), .OC_HS_I(oc_hs), .OC_LS_I(oc_ls),
		.TEMP_WARN_I(temp_warn), .TEMP_HOT_I(temp_hot), .HS_ON_O(hs_on), .LS_ON_O(ls_on),
		.HIZ_O(hiz), .PULLDOWN_O(pd), .FAULT_N_I(fault_n), .FAULT_N_O(fault_o),
		.FAULT_N_OE_O(fault_oe), .OVERTEMP_WARNING_N_I(warn_n), .OVERTEMP_WARNING_N_O(warn_o),
		.OVERTEMP_WARNING_N_OE_O(warn_oe), .IRQ_O(irq));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Waits n edges, then lets that edge's updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One AHB-Lite single word transfer; read data lands in rdat
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rdat = hrdata;
		chk("response", {31'h0, hresp}, 32'h0);
	endtask : bus

	// Asks the controller model for clear pulses and waits for the filter
	task automatic clear(input logic [1:0] p);
		@(posedge clk) pulse <= p;
		@(posedge clk) pulse <= 2'b00;
		cyc(24);
	endtask : clear

	task automatic restart(input logic m);
		@(posedge clk) rst_b <= 1'b0;
		mode <= m;
		cyc(2);
		@(posedge clk) rst_b <= 1'b1;
		cyc(12);
	endtask : restart

	task automatic close_out();
		$display("Checks made %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// Cuts a hang short; the tests need under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		close_out();
	end

	// Scenarios
	initial begin
		{hsel, hwrite, temp_warn, temp_hot, mode, pulse, pwm, oc_hs, oc_ls, haddr, hwdata} = '0;
		htrans = 2'h0;
		hold = 2'b01;
		hsize = 3'h2;
		rst_b = 1'b0;
		cyc(2);
		@(posedge clk) rst_b <= 1'b1;
		cyc(12);
		// Held pair clear floats its bridges with the pulldown on; other pair runs
		chk("hiz", hiz, 4'b0011);
		chk("pulldown", pd, 4'b0011);
		chk("fault pin", fault_n, 1'b1);
		@(posedge clk) hold <= 2'b00;
		cyc(12);
		chk("hiz", hiz, 4'h0);
		bus(OFS_IMASK, 1'b1, 32'h3ff);
		bus(OFS_IMASK, 1'b0, 32'h0);
		chk("mask", rdat, 32'h3ff);
		bus(OFS_ISTAT, 1'b1, 32'h3ff);
		bus(8'h0c, 1'b0, 32'h0);
		chk("unmapped", rdat, 32'h0);
		// High-side trip while limiting: low FET takes over until a new PWM cycle
		@(posedge clk) pwm <= 4'b0001;
		cyc(12);
		chk("hs on", hs_on[0], 1'b1);
		@(posedge clk) oc_hs <= 4'b0001;
		cyc(10);
		chk("hs on", hs_on[0], 1'b0);
		chk("ls on", ls_on[0], 1'b1);
		chk("hiz", hiz, 4'h0);
		chk("fault pin", fault_n, 1'b1);
		@(posedge clk) oc_hs <= 4'h0;
		cyc(12);
		chk("hs on", hs_on[0], 1'b0);
		@(posedge clk) pwm <= 4'h0;
		cyc(12);
		@(posedge clk) pwm <= 4'b0001;
		cyc(12);
		chk("hs on", hs_on[0], 1'b1);
		// Low-side trip: both FETs of that bridge off
		@(posedge clk) oc_ls <= 4'b0010;
		cyc(10);
		chk("ls on", ls_on[1], 1'b0);
		chk("hs on", hs_on[1], 1'b0);
		@(posedge clk) oc_ls <= 4'h0;
		bus(OFS_ISTAT, 1'b0, 32'h0);
		chk("limit events", rdat[7:4], 4'b0011);
		chk("irq", irq, 1'b1);
		bus(OFS_ISTAT, 1'b1, 32'h3ff);
		cyc(2);
		chk("irq", irq, 1'b0);
		@(posedge clk) pwm <= 4'b0011;
		// Trip that limiting cannot contain: only that bridge latched off
		@(posedge clk) oc_ls <= 4'b1000;
		cyc(30);
		chk("hiz", hiz, 4'h0);
		cyc(40);
		chk("hiz", hiz, 4'b1000);
		chk("fault pin", fault_n, 1'b0);
		@(posedge clk) oc_ls <= 4'h0;
		bus(OFS_STATE, 1'b0, 32'h0);
		chk("state shut", rdat[3:0], 4'b1000);
		clear(2'b01);
		chk("hiz", hiz, 4'b1000);
		clear(2'b10);
		chk("hiz", hiz, 4'h0);
		chk("fault pin", fault_n, 1'b1);
		// Latched mode: a trip shuts its own bridge at once and holds it
		restart(1'b1);
		@(posedge clk) oc_hs <= 4'b0100;
		cyc(10);
		chk("hiz", hiz, 4'b0100);
		@(posedge clk) oc_hs <= 4'h0;
		cyc(20);
		chk("hiz", hiz, 4'b0100);
		clear(2'b10);
		chk("hiz", hiz, 4'h0);
		// Thermal: warning pin, then every bridge off until both pairs clear
		bus(OFS_ISTAT, 1'b1, 32'h3ff);
		@(posedge clk) temp_warn <= 1'b1;
		cyc(10);
		chk("warn pin", warn_n, 1'b0);
		chk("fault pin", fault_n, 1'b1);
		@(posedge clk) temp_hot <= 1'b1;
		cyc(10);
		chk("hiz", hiz, 4'hf);
		chk("fault pin", fault_n, 1'b0);
		chk("irq", irq, 1'b0);
		bus(OFS_IMASK, 1'b1, 32'h200);
		cyc(2);
		chk("irq", irq, 1'b1);
		@(posedge clk) {temp_warn, temp_hot} <= 2'b00;
		cyc(10);
		chk("warn pin", warn_n, 1'b1);
		chk("hiz", hiz, 4'hf);
		clear(2'b01);
		chk("hiz", hiz, 4'hf);
		clear(2'b10);
		chk("hiz", hiz, 4'h0);
		bus(OFS_ISTAT, 1'b0, 32'h0);
		chk("temp events", rdat[9:8], 2'b11);
		bus(OFS_ISTAT, 1'b1, 32'h300);
		cyc(2);
		chk("irq", irq, 1'b0);
		close_out();
	end
endmodule : bop_top_tb_top
